// [src/updown_counter_pkg.sv]
package updown_counter_pkg;

  // register word width
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned BE_W = 4;

  // byte offsets of the registers
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 5'h04;
  localparam logic [ADDR_W-1:0] ADDR_COUNT = 5'h08;
  localparam logic [ADDR_W-1:0] ADDR_LOAD = 5'h0c;
  localparam logic [ADDR_W-1:0] ADDR_END = 5'h10;

  // control register fields
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_MAIN_LSB = 2;
  localparam int unsigned CTRL_CANCEL_BIT = 4;
  localparam int unsigned CTRL_DIR_EXT_BIT = 5;
  localparam int unsigned CTRL_DIR_DOWN_BIT = 6;
  localparam int unsigned CTRL_SW_GATE_BIT = 7;
  localparam int unsigned CTRL_USED_W = 8;

  // status register fields
  localparam int unsigned STAT_OVER_BIT = 0;
  localparam int unsigned STAT_UNDER_BIT = 1;
  localparam int unsigned STAT_ZERO_BIT = 2;
  localparam int unsigned STAT_GATE_BIT = 3;
  localparam int unsigned STAT_DOWN_BIT = 4;
  localparam int unsigned STAT_UP_BIT = 5;

  // operating modes
  localparam logic [1:0] MODE_CONT = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;
  localparam logic [1:0] MODE_PERIODIC = 2'h2;

  // main count direction settings
  localparam logic [1:0] MAIN_NONE = 2'h0;
  localparam logic [1:0] MAIN_UP = 2'h1;
  localparam logic [1:0] MAIN_DOWN = 2'h2;

  // counting limits and reset values
  localparam logic [DATA_W-1:0] HIGH_LIMIT = 32'h7fffffff;
  localparam logic [DATA_W-1:0] LOW_LIMIT = 32'h80000000;
  localparam logic [DATA_W-1:0] ONE = 32'h00000001;
  localparam logic [DATA_W-1:0] ZERO = 32'h00000000;
  localparam logic [CTRL_USED_W-1:0] CTRL_RESET = 8'h00;
  localparam logic [DATA_W-1:0] COUNT_RESET = 32'h00000000;
  localparam logic [DATA_W-1:0] LOAD_RESET = 32'h00000000;
  localparam logic [DATA_W-1:0] END_RESET = 32'h7fffffff;

  // internal gate states
  typedef enum logic [2:0] {
    GATE_CLOSED = 3'b001,
    GATE_OPEN = 3'b010,
    GATE_HALTED = 3'b100
  } gate_state_e;

endpackage

// [src/gated_updown_counter.sv]
// The implementer's own choices: the register addresses and register access over Avalon-MM.
module gated_updown_counter
  import updown_counter_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic rst_b, // async reset, active low
  input wire logic [ADDR_W-1:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [DATA_W-1:0] avs_writedata, // write data
  input wire logic [BE_W-1:0] avs_byteenable, // write byte lanes
  output logic [DATA_W-1:0] avs_readdata, // read data
  output logic avs_waitrequest, // stall while high
  input wire logic count_in, // encoder count pulses
  input wire logic dir_in, // external direction, high is down
  input wire logic gate_in, // hardware gate level
  output logic [DATA_W-1:0] count_value, // current count
  output logic over_limit_flag, // sticky overflow
  output logic under_limit_flag, // sticky underflow
  output logic zero_cross_flag, // sticky zero crossing
  output logic gate_open // internal gate status
);

  logic [CTRL_USED_W-1:0] ctrl;
  logic [DATA_W-1:0] count;
  logic [DATA_W-1:0] load_val;
  logic [DATA_W-1:0] end_val;
  logic ack;
  logic count_in_q;
  logic gate_ctl_q;
  logic last_down;
  logic last_up;
  gate_state_e gate_st;
  gate_state_e next_gate_st;
  logic [DATA_W-1:0] next_count;
  logic over_set;
  logic under_set;
  logic zero_set;
  logic auto_close;
  logic counted;
  logic [DATA_W-1:0] wr_merged;
  logic [DATA_W-1:0] read_mux;
  logic [1:0] mode;
  logic [1:0] main_dir;
  logic cancel_gate;
  logic dir_down;
  logic pulse;
  logic gate_ctl;
  logic gate_rise;
  logic bus_wr;
  logic wr_ctrl;
  logic wr_status;
  logic wr_count;
  logic wr_load;
  logic wr_end;
  logic reload;
  logic step_ok;
  logic status_clr;

  // merge write data into old value by byte lane
  // lanes the master leaves off keep their old bytes
  function automatic logic [DATA_W-1:0] lane_merge(
    input logic [DATA_W-1:0] old_v,
    input logic [DATA_W-1:0] new_v,
    input logic [BE_W-1:0] be
  );
    logic [DATA_W-1:0] res;
    res = old_v;
    for (int i = 0; i < BE_W; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // configuration fields
  // mode 3 reloads at the main-direction end without halting and wraps at the limits; main 3 wraps at the limits, never halts, no zero flag
  assign mode = ctrl[CTRL_MODE_LSB +: 2];
  assign main_dir = ctrl[CTRL_MAIN_LSB +: 2];
  assign cancel_gate = ctrl[CTRL_CANCEL_BIT];
  assign dir_down = ctrl[CTRL_DIR_EXT_BIT] ? dir_in : ctrl[CTRL_DIR_DOWN_BIT];

  // edge detection on count and gate control
  // history flops reset to the idle low level of both lines
  assign pulse = count_in & ~count_in_q;
  assign gate_ctl = ctrl[CTRL_SW_GATE_BIT] & gate_in;
  assign gate_rise = gate_ctl & ~gate_ctl_q;

  // bus decode: a write takes effect on the acknowledged cycle
  // one ack flop serves reads and writes, which never overlap
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  assign bus_wr = avs_write & ack;
  assign wr_ctrl = bus_wr & (avs_address == ADDR_CTRL);
  assign wr_status = bus_wr & (avs_address == ADDR_STATUS);
  assign wr_count = bus_wr & (avs_address == ADDR_COUNT);
  assign wr_load = bus_wr & (avs_address == ADDR_LOAD);
  assign wr_end = bus_wr & (avs_address == ADDR_END);

  // byte-lane merge for count writes
  assign wr_merged = lane_merge(count, avs_writedata, avs_byteenable);

  // reopening the gate: reload on cancel or single main-direction restart
  assign reload = gate_rise & (gate_st != GATE_OPEN) &
                  (cancel_gate |
                   ((mode == MODE_SINGLE) & (main_dir != MAIN_NONE) &
                    (gate_st == GATE_HALTED)));

  // pulses count only with the gate open and held open
  // a pulse in the closing cycle is dropped, not counted late
  assign step_ok = (gate_st == GATE_OPEN) & gate_ctl & pulse;

  // next count value and event detection
  // priority: bus write, then gate reload, then count pulse
  always_comb begin
    next_count = count;
    over_set = 1'b0;
    under_set = 1'b0;
    zero_set = 1'b0;
    auto_close = 1'b0;
    counted = 1'b0;
    if (wr_count) begin
      next_count = wr_merged;
      zero_set = (wr_merged == ZERO);
    end else if (reload) begin
      next_count = load_val;
      zero_set = (load_val == ZERO);
    end else if (step_ok) begin
      counted = 1'b1;
      if (!dir_down) begin
        if ((mode != MODE_CONT) && (main_dir == MAIN_UP) &&
            (count == end_val - ONE)) begin
          next_count = load_val;
          over_set = 1'b1;
          auto_close = (mode == MODE_SINGLE);
        end else if (count == HIGH_LIMIT) begin
          over_set = 1'b1;
          if ((mode == MODE_PERIODIC) && (main_dir == MAIN_NONE)) begin
            next_count = load_val;
          end else begin
            next_count = LOW_LIMIT;
          end
          auto_close = (mode == MODE_SINGLE) && (main_dir == MAIN_NONE);
        end else begin
          next_count = count + ONE;
        end
      end else begin
        if ((mode != MODE_CONT) && (main_dir == MAIN_DOWN) && (count == ONE)) begin
          next_count = load_val;
          under_set = 1'b1;
          auto_close = (mode == MODE_SINGLE);
        end else if (count == LOW_LIMIT) begin
          under_set = 1'b1;
          if ((mode == MODE_PERIODIC) && (main_dir == MAIN_NONE)) begin
            next_count = load_val;
          end else begin
            next_count = HIGH_LIMIT;
          end
          auto_close = (mode == MODE_SINGLE) && (main_dir == MAIN_NONE);
        end else begin
          next_count = count - ONE;
        end
      end
      zero_set = (next_count == ZERO);
    end
    zero_set = zero_set & (main_dir == MAIN_NONE);
  end

  // internal gate state machine
  // halted needs a fresh rising edge; a level alone never reopens it
  always_comb begin
    next_gate_st = gate_st;
    case (gate_st)
      GATE_CLOSED: begin
        if (gate_rise) begin
          next_gate_st = GATE_OPEN;
        end
      end
      GATE_OPEN: begin
        if (!gate_ctl) begin
          next_gate_st = GATE_CLOSED;
        end else if (auto_close) begin
          next_gate_st = GATE_HALTED;
        end
      end
      GATE_HALTED: begin
        if (gate_rise) begin
          next_gate_st = GATE_OPEN;
        end
      end
      default: begin
        next_gate_st = GATE_CLOSED;
      end
    endcase
  end

  // gate state register
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      gate_st <= GATE_CLOSED;
    end else begin
      gate_st <= next_gate_st;
    end
  end

  // input edge history
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      count_in_q <= 1'b0;
      gate_ctl_q <= 1'b0;
    end else begin
      count_in_q <= count_in;
      gate_ctl_q <= gate_ctl;
    end
  end

  // count register
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      count <= COUNT_RESET;
    end else begin
      count <= next_count;
    end
  end

  // last counting direction
  // reset value shows up-count before the first pulse
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      last_down <= 1'b0;
      last_up <= 1'b1;
    end else if (counted) begin
      last_down <= dir_down;
      last_up <= ~dir_down;
    end
  end

  // write-one-to-clear strobe, lane 0 carries the flag bits
  assign status_clr = wr_status & avs_byteenable[0];

  // sticky overflow flag; a set in the clearing cycle wins
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      over_limit_flag <= 1'b0;
    end else if (over_set) begin
      over_limit_flag <= 1'b1;
    end else if (status_clr && avs_writedata[STAT_OVER_BIT]) begin
      over_limit_flag <= 1'b0;
    end
  end

  // sticky underflow flag; a set in the clearing cycle wins
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      under_limit_flag <= 1'b0;
    end else if (under_set) begin
      under_limit_flag <= 1'b1;
    end else if (status_clr && avs_writedata[STAT_UNDER_BIT]) begin
      under_limit_flag <= 1'b0;
    end
  end

  // sticky zero-crossing flag; a set in the clearing cycle wins
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      zero_cross_flag <= 1'b0;
    end else if (zero_set) begin
      zero_cross_flag <= 1'b1;
    end else if (status_clr && avs_writedata[STAT_ZERO_BIT]) begin
      zero_cross_flag <= 1'b0;
    end
  end

  // configuration registers
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= CTRL_RESET;
      load_val <= LOAD_RESET;
      end_val <= END_RESET;
    end else begin
      if (wr_ctrl && avs_byteenable[0]) begin
        ctrl <= avs_writedata[CTRL_USED_W-1:0];
      end
      if (wr_load) begin
        load_val <= lane_merge(load_val, avs_writedata, avs_byteenable);
      end
      if (wr_end) begin
        end_val <= lane_merge(end_val, avs_writedata, avs_byteenable);
      end
    end
  end

  // read multiplexer, unmapped reads give zero
  // status bits above the flags are read-only
  always_comb begin
    read_mux = ZERO;
    case (avs_address)
      ADDR_CTRL: begin
        read_mux[CTRL_USED_W-1:0] = ctrl;
      end
      ADDR_STATUS: begin
        read_mux[STAT_OVER_BIT] = over_limit_flag;
        read_mux[STAT_UNDER_BIT] = under_limit_flag;
        read_mux[STAT_ZERO_BIT] = zero_cross_flag;
        read_mux[STAT_GATE_BIT] = (gate_st == GATE_OPEN);
        read_mux[STAT_DOWN_BIT] = last_down;
        read_mux[STAT_UP_BIT] = last_up;
      end
      ADDR_COUNT: begin
        read_mux = count;
      end
      ADDR_LOAD: begin
        read_mux = load_val;
      end
      ADDR_END: begin
        read_mux = end_val;
      end
      default: begin
        read_mux = ZERO;
      end
    endcase
  end

  // one-wait-state acknowledge and registered read data
  // ack clears itself, so each request costs two clock edges
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ack <= 1'b0;
      avs_readdata <= ZERO;
    end else begin
      ack <= (avs_read | avs_write) & ~ack;
      if (avs_read && !ack) begin
        avs_readdata <= read_mux;
      end
    end
  end

  // count output straight from its register
  assign count_value = count;

  // gate status registered alongside the gate state
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      gate_open <= 1'b0;
    end else begin
      gate_open <= (next_gate_st == GATE_OPEN);
    end
  end

endmodule

// [dv/counter_monitor.sv]
module counter_monitor
  import updown_counter_pkg::*;
(
  input wire logic clk_sys, // clock
  input wire logic rst_b, // reset, active low
  input wire logic [ADDR_W-1:0] avs_address, // bus address
  input wire logic avs_write, // bus write
  input wire logic avs_waitrequest, // bus stall
  input wire logic count_in, // count pulses
  input wire logic gate_in, // gate pin
  input wire logic [DATA_W-1:0] count_value, // count
  input wire logic over_limit_flag, // overflow
  input wire logic under_limit_flag, // underflow
  input wire logic zero_cross_flag, // zero crossing
  input wire logic gate_open // gate status
);
  timeunit 1ns;
  timeprecision 1ns;
  logic wr_ack;
  logic st_clr;

  // write completing at this edge, and a status clear among them
  assign wr_ack = avs_write & ~avs_waitrequest;
  assign st_clr = wr_ack & (avs_address == ADDR_STATUS);

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  // gate and limit behaviour
  a_gate_freeze: assert property ((!gate_open && !wr_ack) ##1 !gate_open |-> $stable(count_value))
    else $error("count moved while gate closed");
  a_gate_close: assert property (!gate_in |=> !gate_open)
    else $error("gate stayed open without control");
  a_gate_cause: assert property ($rose(gate_open) |-> $past(gate_in))
    else $error("gate opened without control");
  a_over_wrap: assert property (
    (count_value == HIGH_LIMIT && !wr_ack) ##1 count_value == LOW_LIMIT |-> over_limit_flag)
    else $error("wrap up without overflow flag");
  a_under_wrap: assert property (
    (count_value == LOW_LIMIT && !wr_ack) ##1 count_value == HIGH_LIMIT |-> under_limit_flag)
    else $error("wrap down without underflow flag");
  a_zero_lands: assert property ($rose(zero_cross_flag) |-> count_value == ZERO)
    else $error("zero flag with nonzero count");
  a_flags_sticky: assert property (
    $fell(over_limit_flag) || $fell(under_limit_flag) || $fell(zero_cross_flag)
    |-> $past(st_clr))
    else $error("flag dropped without clear");
  a_count_cause: assert property (
    count_value != $past(count_value) && !$past(wr_ack) && !$rose(gate_open)
    |-> $past(count_in) && !$past(count_in, 2))
    else $error("count changed without pulse");

  // main scenarios
  c_over: cover property ($rose(over_limit_flag));
  c_under: cover property ($rose(under_limit_flag));
  c_zero: cover property ($rose(zero_cross_flag));
  c_auto_close: cover property ($fell(gate_open) && gate_in);
endmodule

// [dv/encoder_source.sv]
module encoder_source (
  input wire logic clk_sys, // clock
  output logic count_in, // count pulses
  output logic dir_in, // direction, high is down
  output logic gate_in // gate level
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle line levels
  initial begin
    count_in = 1'b0;
    dir_in = 1'b0;
    gate_in = 1'b1;
  end

  // one pulse, then gap + 1 idle cycles for a slow source
  task automatic pulse(input logic dn, input int gap);
    @(posedge clk_sys);
    dir_in <= dn;
    count_in <= 1'b1;
    @(posedge clk_sys);
    count_in <= 1'b0;
    repeat (gap + 1) @(posedge clk_sys);
  endtask

  // gate level change, new rising edge restarts
  task automatic gate(input logic v);
    @(posedge clk_sys);
    gate_in <= v;
    repeat (2) @(posedge clk_sys);
  endtask
endmodule

// [dv/gated_updown_counter_modes_bench.sv]
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin err_count++; $display("FAIL %s exp %h got %h", n, e, g); end end
module gated_updown_counter_modes_bench
  import updown_counter_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 0;
  logic rst_b = 0;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 0;
  logic avs_write = 0;
  logic [DATA_W-1:0] avs_writedata = '0;
  logic [BE_W-1:0] avs_byteenable = 4'hf;
  logic [DATA_W-1:0] avs_readdata, count_value, q;
  logic avs_waitrequest, count_in, dir_in, gate_in, over_limit_flag;
  logic under_limit_flag, zero_cross_flag, gate_open;
  int err_count = 0, tests_run = 0, cyc = 0, mc = 0, mld = 0, mend = 0;
  bit mov = 0, mun = 0, mze = 0, mop = 0, mhalt = 0;
  logic [7:0] mctl = 8'h00;
  logic [31:0] seed = 32'hde8802b6;
  // ctrl, load, end, start count, pulses; directions never pass the far limit
  logic [7:0] t_ctl [11] = '{8'h80, 8'hc0, 8'h81, 8'hd1, 8'h85, 8'hc9, 8'h82, 8'h86,
    8'hca, 8'ha2, 8'ha0};
  int t_ld [11] = '{0, 0, 5, 0, 2, 3, 7, -1, 2, 0, 0};
  int t_end [11] = '{0, 0, 0, 0, 5, 0, 0, 2, 0, 0, 0};
  int t_cnt [11] = '{32'h7ffffffe, 32'h80000001, 32'h7fffffff, 32'h80000000, 2, 3,
    32'h7ffffffe, -1, 2, 0, 3};
  int t_n [11] = '{3, 3, 2, 2, 4, 4, 3, 5, 4, 12, 12};

  always #50 clk_sys = ~clk_sys;

  gated_updown_counter dut (.clk_sys, .rst_b, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .count_in, .dir_in,
    .gate_in, .count_value, .over_limit_flag, .under_limit_flag, .zero_cross_flag, .gate_open);
  encoder_source src (.clk_sys, .count_in, .dir_in, .gate_in);

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // reference step of the count for one pulse
  function automatic void mstep(input logic dn);
    logic md;
    logic none;
    md = mctl[1:0] != MODE_CONT;
    none = mctl[3:2] == MAIN_NONE;
    if (!mop) return;
    if (!dn && mc == ((md && mctl[3:2] == MAIN_UP) ? mend - 1 : 32'sh7fffffff) ||
        dn && mc == ((md && mctl[3:2] == MAIN_DOWN) ? 1 : 32'sh80000000)) begin
      if (dn) mun = 1;
      else mov = 1;
      mc = (md && (!none || mctl[1:0] == MODE_PERIODIC)) ? mld : (dn ? 32'sh7fffffff : 32'sh80000000);
      if (mctl[1:0] == MODE_SINGLE) begin
        mop = 0;
        mhalt = 1;
      end
    end else mc = dn ? mc - 1 : mc + 1;
    if (mc == 0 && none) mze = 1;
  endfunction

  // reference gate opening: canceling, or halted main-direction single, reloads
  function automatic void mgate();
    bit rl;
    rl = mctl[4] || (mhalt && mctl[1:0] == MODE_SINGLE && mctl[3:2] != MAIN_NONE);
    if (mop) return;
    mop = 1;
    mhalt = 0;
    if (rl) mc = mld;
    if (rl && mc == 0 && mctl[3:2] == MAIN_NONE) mze = 1;
  endfunction

  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_write <= wr;
    avs_read <= !wr;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic check();
    @(negedge clk_sys);
    `CHK("count", 32'(mc), count_value)
    `CHK("over", mov, over_limit_flag)
    `CHK("under", mun, under_limit_flag)
    `CHK("zero", mze, zero_cross_flag)
    `CHK("gate", mop, gate_open)
  endtask

  // random direction pin and gap; setting direction unless pin selected
  task automatic step();
    seed = lfsr(seed);
    src.pulse(seed[0], int'(seed[2:1]));
    mstep(mctl[5] ? seed[0] : mctl[6]);
    check();
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 6000) begin
      err_count++;
      test_done();
    end
  end

  // main sequence
  initial begin
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    check();
    bus(0, ADDR_END, 0);
    `CHK("end_reset", END_RESET, q)
    bus(0, 5'h14, 0);
    `CHK("unmapped", 32'h00000000, q)
    for (int i = 0; i < 11; i++) begin
      bus(1, ADDR_CTRL, 0);
      mctl = 8'h00;
      mop = 0;
      bus(1, ADDR_LOAD, t_ld[i]);
      mld = t_ld[i];
      mend = (t_end[i] == 0) ? 32'sh7fffffff : t_end[i];
      bus(1, ADDR_END, mend);
      bus(1, ADDR_CTRL, {24'h0, t_ctl[i]});
      mctl = t_ctl[i];
      mgate();
      bus(1, ADDR_COUNT, t_cnt[i]);
      mc = t_cnt[i];
      bus(1, ADDR_STATUS, 32'h7);
      {mov, mun, mze} = 3'b000;
      check();
      repeat (t_n[i]) step();
      src.gate(0);
      mop = 0;
      step();
      src.gate(1);
      mgate();
      check();
      repeat (2) step();
      bus(0, ADDR_COUNT, 0);
      `CHK("count_reg", 32'(mc), q)
    end
    bus(1, ADDR_STATUS, 32'h7);
    {mov, mun, mze} = 3'b000;
    bus(1, ADDR_COUNT, 0);
    mc = 0;
    mze = 1;
    check();
    @(posedge clk_sys);
    avs_byteenable <= 4'h1;
    bus(1, ADDR_COUNT, 32'h123456ab);
    avs_byteenable <= 4'hf;
    mc = 32'h000000ab;
    check();
    test_done();
  end
endmodule

bind gated_updown_counter counter_monitor mon (.clk_sys, .rst_b, .avs_address, .avs_write,
  .avs_waitrequest, .count_in, .gate_in, .count_value, .over_limit_flag, .under_limit_flag,
  .zero_cross_flag, .gate_open);
